/* sdf_filter.sv */
// Two-stage decimation filter: sinc5 by 64 followed by a programmable
// averager. Assumes the modulator bit is synchronous to clk_sys and that
// the serial side reads results through the register port.

// ****************************************************************
// Filter top
// ****************************************************************
// Functional notes
// - Take one modulator sample every four clocks
// - First stage is sinc5, decimate 64
// - Sinc stage result every 256 clocks
// - Averager sums count of sinc results
// - Low-rate codes map to large counts
// - High-rate codes map; F0h bypasses averager
// - Output rate is clock/(256*count)
// - Response is sinc5 times sinc1
// - Notches at data rate and multiples
// - Larger count narrows bandwidth
// - Bandwidth follows from count and clock
// - Ready stays high until settled result
// - Response repeats at modulator rate
module sdf_filter
(
    input  wire logic                  clk_sys,            // 100 MHz clock
    input  wire logic                  rst_n,              // Async reset, active low
    input  wire logic                  clk_en,             // Freezes all state
    input  wire logic                  sync_req,           // Synchronise pulse
    input  wire logic                  mod_bit,            // Modulator bitstream
    input  wire logic [3:0]            reg_addr,           // Register address
    input  wire logic [31:0]           reg_wdata,          // Write data
    input  wire logic                  reg_wr,             // Write strobe
    input  wire logic                  reg_rd,             // Read strobe
    output logic      [31:0]           reg_rdata,          // Read data, next cycle
    output logic                       conversion_ready_n, // Low when data ready
    output sdf_pkg::sdf_result_t       result              // Result to serial side
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]                 data_rate_select_q;       // Rate code register
    logic [7:0]                 data_rate_select_d;
    logic [1:0]                 mod_cnt_q;                // Modulator phase
    logic [1:0]                 mod_cnt_d;
    logic                       mod_stb;                  // Sample strobe
    logic                       sinc_stb;                 // Sinc5 result strobe
    logic [sdf_pkg::ACC_W-1:0]  sinc_data;
    logic                       restart;                  // Sync or rate change
    logic [sdf_pkg::AVG_W-1:0]  avg_cnt_q;                // Results summed so far
    logic [sdf_pkg::AVG_W-1:0]  avg_cnt_d;
    logic [sdf_pkg::SUM_W-1:0]  acc_q;                    // Running sum
    logic [sdf_pkg::SUM_W-1:0]  acc_d;
    logic [2:0]                 settle_q;                 // Sinc5 warm-up count
    logic [2:0]                 settle_d;
    logic                       ready_n_q;
    logic                       ready_n_d;
    sdf_pkg::sdf_result_t       res_q;
    sdf_pkg::sdf_result_t       res_d;
    logic [31:0]                rdata_q;
    logic [31:0]                rdata_d;
    logic [sdf_pkg::AVG_W-1:0]  num_ave;                  // Count for current code
    logic                       wr_rate;

    // Average count for a rate code; unlisted codes fall back to bypass
    function automatic logic [sdf_pkg::AVG_W-1:0] rate_to_count(input logic [7:0] rate_code);
        logic [sdf_pkg::AVG_W-1:0] n;
        n = 14'h0001;
        unique case (rate_code)
            8'h03: n = 14'h2ee0;   // 12000
            8'h13: n = 14'h1770;   // 6000
            8'h23: n = 14'h0bb8;   // 3000
            8'h33: n = 14'h07d0;   // 2000
            8'h43: n = 14'h04b0;   // 1200
            8'h53: n = 14'h03e8;   // 1000
            8'h63: n = 14'h0258;   // 600
            8'h72: n = 14'h01f4;   // 500
            8'h82: n = 14'h012c;   // 300
            8'h92: n = 14'h003c;   // 60
            8'ha1: n = 14'h001e;   // 30
            8'hb0: n = 14'h000f;   // 15
            8'hc0: n = 14'h0008;   // 8
            8'hd0: n = 14'h0004;   // 4
            8'he0: n = 14'h0002;   // 2
            default: n = 14'h0001; // F0h and anything unlisted
        endcase
        return n;
    endfunction

    // ****************************************************************
    // Rate register
    // ****************************************************************
    assign wr_rate = reg_wr && (reg_addr == sdf_pkg::ADDR_RATE);

    // Next rate code; bits above 8 ignored
    always_comb
    begin
        data_rate_select_d = data_rate_select_q;
        if (wr_rate)
            data_rate_select_d = reg_wdata[7:0];
    end

    assign num_ave = rate_to_count(data_rate_select_q);

    // any write of a new code restarts the averager
    assign restart = sync_req || (wr_rate && (reg_wdata[7:0] != data_rate_select_q));

    // ****************************************************************
    // Modulator timing
    // ****************************************************************
    // strobe every fourth clock
    always_comb
    begin
        mod_cnt_d = mod_cnt_q + 2'h1;
        if (sync_req)
            mod_cnt_d = '0;
    end
    assign mod_stb = (mod_cnt_q == sdf_pkg::MOD_LAST);

    // images at modulator rate are inherent to decimation
    sdf_sinc5 u_sinc5
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .restart  (sync_req),
        .mod_stb  (mod_stb),
        .mod_bit  (mod_bit),
        .out_stb  (sinc_stb),
        .out_data (sinc_data)
    );

    // ****************************************************************
    // Averager and ready flag
    // ****************************************************************
    // A sinc result landing with a restart is dropped: it mixes old data
    always_comb
    begin
        avg_cnt_d       = avg_cnt_q;
        acc_d           = acc_q;
        settle_d        = settle_q;
        ready_n_d       = ready_n_q;
        res_d           = res_q;
        res_d.valid     = 1'b0;
        if (restart)
        begin
            avg_cnt_d = '0;
            acc_d     = '0;
            if (sync_req)
            begin
                settle_d  = '0;
                ready_n_d = 1'b1;
            end
        end
        else if (sinc_stb)
        begin
            if (settle_q != sdf_pkg::SETTLE_LAST)
                // Sinc5 needs five outputs before its history is full
                settle_d = settle_q + 3'h1;
            else if (avg_cnt_q + 14'h0001 == num_ave)
            begin
                res_d.sum   = acc_q + {{(sdf_pkg::SUM_W-sdf_pkg::ACC_W){1'b0}}, sinc_data};
                res_d.count = num_ave;
                res_d.valid = 1'b1;
                ready_n_d   = 1'b0;
                avg_cnt_d   = '0;
                acc_d       = '0;
            end
            else
            begin
                // boxcar sum after sinc5 gives the product response
                // boxcar of count places notches at data rate
                // bandwidth set by count and clock alone
                acc_d     = acc_q + {{(sdf_pkg::SUM_W-sdf_pkg::ACC_W){1'b0}}, sinc_data};
                avg_cnt_d = avg_cnt_q + 14'h0001;
            end
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Unmapped addresses read zero
    always_comb
    begin
        rdata_d = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                sdf_pkg::ADDR_RATE:   rdata_d = {24'h000000, data_rate_select_q};
                sdf_pkg::ADDR_STATUS: rdata_d = {29'h00000000, settle_q != sdf_pkg::SETTLE_LAST,
                                                 restart, ready_n_q};
                sdf_pkg::ADDR_DATA:   rdata_d = res_q.sum[sdf_pkg::SUM_W-1 -: 32];
                sdf_pkg::ADDR_COUNT:  rdata_d = {18'h00000, num_ave};
                default:              rdata_d = '0;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_rate_select_q <= sdf_pkg::RATE_RESET;
            mod_cnt_q          <= '0;
            avg_cnt_q          <= '0;
            acc_q              <= '0;
            settle_q           <= '0;
            ready_n_q          <= 1'b1;
            res_q              <= '0;
            rdata_q            <= '0;
        end
        else if (clk_en)
        begin
            data_rate_select_q <= data_rate_select_d;
            mod_cnt_q          <= mod_cnt_d;
            avg_cnt_q          <= avg_cnt_d;
            acc_q              <= acc_d;
            settle_q           <= settle_d;
            ready_n_q          <= ready_n_d;
            res_q              <= res_d;
            rdata_q            <= rdata_d;
        end
    end

    assign reg_rdata          = rdata_q;
    assign conversion_ready_n = ready_n_q;
    assign result             = res_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // strobes four clocks apart
    a_mod_strobe_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mod_stb && clk_en && !sync_req) ##1 clk_en [*3] |-> !mod_stb)
        else $error("modulator strobe spacing wrong");

    // sinc output never back to back
    a_sinc_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sinc_stb |=> !sinc_stb)
        else $error("sinc5 strobes too close");

    a_sync_ready_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sync_req && clk_en) |=> conversion_ready_n)
        else $error("ready not cleared by sync");

    a_rate_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (restart && clk_en) |=> (avg_cnt_q == '0 && acc_q == '0))
        else $error("averager not restarted");

    a_result_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        result.valid |-> result.count == num_ave)
        else $error("result count mismatch");

    // result only after a sinc strobe
    a_result_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
        result.valid |-> $past(sinc_stb))
        else $error("result without sinc output");

    a_bypass_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        data_rate_select_q == 8'hf0 |-> num_ave == 14'h0001)
        else $error("bypass count wrong");

    a_slow_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        data_rate_select_q == 8'h03 |-> num_ave == 14'h2ee0)
        else $error("slow count wrong");

    // ready only falls together with a result
    a_ready_fall_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(conversion_ready_n) |-> result.valid)
        else $error("ready fell without a result");

    // no result while the sinc5 history is filling
    a_settled_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
        result.valid |-> settle_q == sdf_pkg::SETTLE_LAST)
        else $error("result during warm-up");

    c_result_out:  cover property (@(posedge clk_sys) result.valid);
    c_sync_seen:   cover property (@(posedge clk_sys) sync_req ##1 conversion_ready_n);
    c_rate_change: cover property (@(posedge clk_sys) wr_rate && restart);

endmodule

/* sdf_mod_source.sv */
// Modulator bitstream source that feeds the decimation filter in the bench.
// Assumes the bench supplies a noise bit and a mode select on clk_sys.
module sdf_mod_source
(
    input  wire logic clk_sys,   // System clock
    input  wire logic rst_n,     // Async reset, active low
    input  wire logic noisy,     // High: pass the noise bit on
    input  wire logic noise_bit, // Random bit from the bench
    output logic      mod_bit    // Bit stream into the filter
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Stream generator
    // ****************************************************************
    // All ones gives a known settled level, so sums can be predicted;
    // noise mode only exercises timing, since the sample phase is hidden
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mod_bit <= 1'b1;
        end
        else
        begin
            mod_bit <= noisy ? noise_bit : 1'b1;
        end
    end
endmodule

/* sdf_pkg.sv */
// Package for the two-stage decimation filter.
// Assumes one system clock standing in for the converter master clock.
package sdf_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] ADDR_RATE     = 4'h0;   // data_rate_select
    localparam logic [3:0] ADDR_STATUS   = 4'h1;   // Status word
    localparam logic [3:0] ADDR_DATA     = 4'h2;   // Last result
    localparam logic [3:0] ADDR_COUNT    = 4'h3;   // Active average count
    localparam logic [7:0] RATE_RESET    = 8'hf0;  // Fastest rate after reset

    // ****************************************************************
    // Timing and widths
    // ****************************************************************
    localparam int         MOD_DIV       = 4;      // Clocks per modulator sample
    localparam int         DEC_RATIO     = 64;     // Sinc5 decimation
    localparam int         SINC_ORDER    = 5;
    localparam int         ACC_W         = 31;     // 1 + 5*log2(64)
    localparam int         AVG_W         = 14;     // Holds 12000
    localparam int         SUM_W         = 45;     // ACC_W + AVG_W
    localparam int         SETTLE_OUT    = 5;      // Sinc5 outputs to settle
    localparam logic [1:0] MOD_LAST      = 2'h3;
    localparam logic [5:0] DEC_LAST      = 6'h3f;
    localparam logic [2:0] SETTLE_LAST   = 3'h4;

    // Result handed to the serial side
    typedef struct packed {
        logic              valid;
        logic [SUM_W-1:0]  sum;
        logic [AVG_W-1:0]  count;
    } sdf_result_t;

    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } sdf_bus_t;

endpackage

/* sdf_sinc5.sv */
// Fixed fifth-order sinc decimator, ratio 64, one-bit input stream.
// Assumes sample strobes arrive every four clocks from the parent.
module sdf_sinc5
(
    input  wire logic                        clk_sys,     // System clock
    input  wire logic                        rst_n,       // Async reset
    input  wire logic                        clk_en,      // Freeze when low
    input  wire logic                        restart,     // Clear filter state
    input  wire logic                        mod_stb,     // Modulator sample strobe
    input  wire logic                        mod_bit,     // Modulator bit
    output logic                             out_stb,     // Decimated result strobe
    output logic [sdf_pkg::ACC_W-1:0]        out_data     // Decimated result
);

    // ****************************************************************
    // Integrators and combs
    // ****************************************************************
    // Modular arithmetic: wrap in integrators is undone by the combs
    logic [sdf_pkg::ACC_W-1:0] integ_q [sdf_pkg::SINC_ORDER];
    logic [sdf_pkg::ACC_W-1:0] integ_d [sdf_pkg::SINC_ORDER];
    logic [sdf_pkg::ACC_W-1:0] comb_q  [sdf_pkg::SINC_ORDER];
    logic [sdf_pkg::ACC_W-1:0] comb_d  [sdf_pkg::SINC_ORDER];
    logic [5:0]                dec_q;                       // Decimation phase
    logic [5:0]                dec_d;
    logic                      stb_q;                        // Output strobe
    logic                      stb_d;
    logic [sdf_pkg::ACC_W-1:0] out_q;
    logic [sdf_pkg::ACC_W-1:0] out_d;
    logic [sdf_pkg::ACC_W-1:0] x;                            // Comb chain value

    // Next-state for the whole sinc5 pipeline
    always_comb
    begin
        integ_d = integ_q;
        comb_d  = comb_q;
        dec_d   = dec_q;
        stb_d   = 1'b0;
        out_d   = out_q;
        x       = '0;
        if (restart)
        begin
            // Restart clears all history; a result registered just before it still goes out
            for (int i = 0; i < sdf_pkg::SINC_ORDER; i++)
            begin
                integ_d[i] = '0;
                comb_d[i]  = '0;
            end
            dec_d = '0;
        end
        else if (mod_stb)
        begin
            integ_d[0] = integ_q[0] + {{(sdf_pkg::ACC_W-1){1'b0}}, mod_bit};
            for (int i = 1; i < sdf_pkg::SINC_ORDER; i++)
                integ_d[i] = integ_q[i] + integ_d[i-1];
            dec_d = dec_q + 6'h01;
            // combs run once per 64 samples
            if (dec_q == sdf_pkg::DEC_LAST)
            begin
                x = integ_d[sdf_pkg::SINC_ORDER-1];
                for (int i = 0; i < sdf_pkg::SINC_ORDER; i++)
                begin
                    comb_d[i] = x;
                    x         = x - comb_q[i];
                end
                out_d = x;
                stb_d = 1'b1;
            end
        end
    end

    // Registers only
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < sdf_pkg::SINC_ORDER; i++)
            begin
                integ_q[i] <= '0;
                comb_q[i]  <= '0;
            end
            dec_q <= '0;
            stb_q <= 1'b0;
            out_q <= '0;
        end
        else if (clk_en)
        begin
            integ_q <= integ_d;
            comb_q  <= comb_d;
            dec_q   <= dec_d;
            stb_q   <= stb_d;
            out_q   <= out_d;
        end
    end

    assign out_stb  = stb_q & clk_en;
    assign out_data = out_q;

endmodule

/* sinc5_decimator_with_averager_test.sv */
// Self-checking bench for the two-stage decimation filter.
// Assumes sdf_pkg and sdf_filter are compiled first, clk_en held high.
module sinc5_decimator_with_averager_test;
    timeunit 1ns;
    timeprecision 1ps;

`define CHECK(nm, exp, got) \
    begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

    // ****************************************************************
    // Signals and model tables
    // ****************************************************************
    logic                 clk_sys = 1'b0;   // 100 MHz clock
    logic                 rst_n = 1'b0;     // Reset, active low
    logic                 clk_en = 1'b1;    // Freeze is not exercised
    logic                 sync_req = 1'b0;  // Synchronise pulse
    logic                 noisy = 1'b0;     // Source mode
    logic                 noise_bit = 1'b0; // Random source bit
    logic                 mod_bit;          // Stream into the filter
    logic [3:0]           reg_addr = 4'h0;  // Register address
    logic [31:0]          reg_wdata = 32'h0;// Write data
    logic                 reg_wr = 1'b0;    // Write strobe
    logic                 reg_rd = 1'b0;    // Read strobe
    logic [31:0]          reg_rdata;        // Read data
    logic [31:0]          rd_val;           // Last value read
    logic                 conversion_ready_n; // Ready, active low
    sdf_pkg::sdf_result_t result;           // Result stream
    int                   failures = 0;     // Mismatch count
    int                   samples_checked = 0; // Comparison count
    int                   cycles = 0;       // Timeout counter
    int                   seed = 82654;     // Random seed
    int                   n;                // Measured cycles
    int                   idx;              // Table index
    // Rate code to average count, the bench's own model of the averager
    logic [7:0] codes [16] = '{8'h03, 8'h13, 8'h23, 8'h33, 8'h43, 8'h53, 8'h63, 8'h72,
                               8'h82, 8'h92, 8'ha1, 8'hb0, 8'hc0, 8'hd0, 8'he0, 8'hf0};
    int         counts [16] = '{12000, 6000, 3000, 2000, 1200, 1000, 600, 500,
                                300, 60, 30, 15, 8, 4, 2, 1};

    sdf_filter dut
    (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .clk_en             (clk_en),
        .sync_req           (sync_req),
        .mod_bit            (mod_bit),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .conversion_ready_n (conversion_ready_n),
        .result             (result)
    );

    sdf_mod_source src
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .noisy     (noisy),
        .noise_bit (noise_bit),
        .mod_bit   (mod_bit)
    );

    // ****************************************************************
    // Clock, noise and timeout
    // ****************************************************************
    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        noise_bit <= 1'($random(seed));
    end

    // Whole plan needs about 35k cycles; the ceiling leaves margin
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            complete_run();
        end
    end

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, so sample there
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Counts cycles until the next result pulse, bounded by lim
    task automatic wait_result(input int lim, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
        while (result.valid !== 1'b1 && cnt < lim);
        if (result.valid !== 1'b1)
        begin
            failures++;
            $display("wrong value result wait expected 1 seen 0");
        end
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        reg_read(sdf_pkg::ADDR_RATE, rd_val);
        `CHECK("rate reset", {24'h0, sdf_pkg::RATE_RESET}, rd_val)
        reg_read(sdf_pkg::ADDR_STATUS, rd_val);
        `CHECK("ready after reset", 1'b1, rd_val[0])
        `CHECK("settling after reset", 1'b1, rd_val[2])
        // the table holds the mains-friendly rates the host may pick
        // only listed codes are written, each one mapped
        for (int i = 0; i < 20; i++)
        begin
            idx = (i < 16) ? i : ($random(seed) & 15);
            reg_write(sdf_pkg::ADDR_RATE, {24'h0, codes[idx]});
            reg_read(sdf_pkg::ADDR_COUNT, rd_val);
            `CHECK("count reg", 32'(counts[idx]), rd_val)
            reg_read(sdf_pkg::ADDR_RATE, rd_val);
            `CHECK("rate reg", {24'h0, codes[idx]}, rd_val)
        end
        // Unmapped reads give zero; writes to the count place are ignored
        reg_read(4'hf, rd_val);
        `CHECK("unmapped read", 32'h0, rd_val)
        reg_write(sdf_pkg::ADDR_RATE, 32'h0000_00f0);
        reg_write(sdf_pkg::ADDR_COUNT, 32'h0000_0005);
        reg_read(sdf_pkg::ADDR_COUNT, rd_val);
        `CHECK("count read only", 32'h1, rd_val)
        // ready held high after sync until warm-up is over
        noisy    <= 1'b1;
        @(posedge clk_sys);
        sync_req <= 1'b1;
        @(posedge clk_sys);
        sync_req <= 1'b0;
        n = 0;
        repeat (1000)
        begin
            @(posedge clk_sys);
            #1;
            if (conversion_ready_n === 1'b1) n++;
        end
        `CHECK("ready held", 1000, n)
        wait_result(2000, n);
        @(posedge clk_sys);
        #1;
        `CHECK("ready falls", 1'b0, conversion_ready_n)
        noisy <= 1'b0;
        // Gap between results and the averaged sum, all-ones stream
        for (int i = 10; i < 16; i++)
        begin
            reg_write(sdf_pkg::ADDR_RATE, {24'h0, codes[i]});
            wait_result(counts[i] * 256 + 600, n);
            wait_result(counts[i] * 256 + 8, n);
            `CHECK("result gap", counts[i] * 256, n)
            `CHECK("result count", 14'(counts[i]), result.count)
            `CHECK("result sum", 45'(counts[i]) * 45'h40000000, result.sum)
        end
        // rate change mid-average restarts the sum
        reg_write(sdf_pkg::ADDR_RATE, 32'h0000_00d0);
        wait_result(4 * 256 + 600, n);
        repeat (300) @(posedge clk_sys);
        reg_write(sdf_pkg::ADDR_RATE, 32'h0000_00c0);
        wait_result(8 * 256 + 300, n);
        `CHECK("restart gap", 1'b1, 1'(n >= 7 * 256 && n <= 8 * 256 + 8))
        `CHECK("restart sum", 45'h200000000, result.sum)
        `CHECK("restart count", 14'h8, result.count)
        complete_run();
    end
endmodule
